// ===== rtl/tarto_pkg.sv
// Constants, carrier types and states for the table and register transfer unit.
// Assumes a core that supplies the instruction word, index bits, accumulator, B and PC values.
// Behaviour
// - A word of the form 00100ppppp is the page table read; its low five bits are the page, and it takes three cycles.
// - The page table read addresses program memory with the page as the page part and index bits 2..0 over accumulator bits 3..0 as the low part.
// - The fetched byte's upper nibble goes to register B and its lower nibble to the accumulator.
// - The index to accumulator move copies the three index bits into accumulator bits 2..0.
// - The index to accumulator move clears accumulator bit 3.
// - With comparator mode selected, the comparator load writes B into value bits 7..4 and the accumulator into bits 3..0.
// - In conversion mode the comparator load leaves the comparator value unchanged and only pulses done.
// - Comparator mode select is bit 3 of the converter control register, 1 meaning comparator mode.
// - The interrupt control read copies all four bits of interrupt control one into the accumulator.
package tarto_pkg;

	localparam int          PAGE_W         = 5;
	localparam int          LOW_W          = 7;
	localparam int          INDEX_W        = 3;
	localparam int          NIB_W          = 4;
	localparam int          INSTR_W        = 10;
	localparam logic [4:0]  PAGE_READ_OPC  = 5'h04;
	localparam int          OPC_HI         = 9;
	localparam int          OPC_LO         = 5;
	localparam int          MODE_SEL_BIT   = 3;
	localparam logic        MODE_COMPARE   = 1'b1;
	localparam int          ROM_HI_NIB     = 7;
	localparam int          ROM_LO_NIB     = 3;
	localparam int          ACC_TOP_BIT    = 3;
	localparam logic [7:0]  COMP_RESET     = 8'h00;
	localparam logic [3:0]  NIB_RESET      = 4'h0;

	typedef struct packed {
		logic [PAGE_W-1:0] page;
		logic [LOW_W-1:0]  low;
	} tarto_pc_t;

	typedef struct packed {
		logic             we;
		logic [NIB_W-1:0] data;
	} tarto_nib_wr_t;

	typedef struct packed {
		logic      we;
		tarto_pc_t pc;
	} tarto_pc_wr_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FETCH = 3'b010,
		ST_LOAD  = 3'b100
	} tarto_state_t;

endpackage

// ===== rtl/tarto_xfer.sv
// Execution unit for the page table read, index move, comparator load and interrupt read.
// Assumes synchronous program memory: data for romAddr is valid the cycle after romRead.
`timescale 1ns/100ps
module tarto_xfer
	import tarto_pkg::*;
#(
	parameter int                 STACK_DEPTH   = 8,
	parameter logic [INSTR_W-1:0] OPC_IDX_MOVE  = 10'h051,
	parameter logic [INSTR_W-1:0] OPC_CMP_LOAD  = 10'h239,
	parameter logic [INSTR_W-1:0] OPC_INT_READ  = 10'h253
)
(
	input  wire logic                           clk_sys,
	input  wire logic                           rstn,
	input  wire logic                           instrValid,
	input  wire logic [INSTR_W-1:0]             instrWord,
	input  wire tarto_pc_t                      pcIn,
	input  wire logic [INDEX_W-1:0]             indexBits,
	input  wire logic [NIB_W-1:0]               accIn,
	input  wire logic [NIB_W-1:0]               regBIn,
	input  wire logic [NIB_W-1:0]               converterControl,
	input  wire logic [NIB_W-1:0]               interruptControlOne,
	input  wire logic [7:0]                     romData,
	output tarto_nib_wr_t                       accWr,
	output tarto_nib_wr_t                       regBWr,
	output tarto_pc_wr_t                        pcWr,
	output tarto_pc_t                           romAddr,
	output logic                                romRead,
	output logic [7:0]                          comparatorValue,
	output logic [$clog2(STACK_DEPTH)-1:0]      stackLevel,
	output logic                                busy,
	output logic                                done,
	output logic                                carryWe,
	output logic                                skipNext
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	tarto_state_t    state;
	tarto_pc_t       returnStack [STACK_DEPTH];
	logic            accepted;
	logic            isPageRead;
	logic            isIdxMove;
	logic            isCmpLoad;
	logic            isIntRead;
	logic            compareMode;
	logic [SP_W-1:0] next_stackLevel;

	function automatic logic decode_page_read(input logic [INSTR_W-1:0] w);
		decode_page_read = (w[OPC_HI:OPC_LO] == PAGE_READ_OPC);
	endfunction

	// The short operations are matched on the whole word, since their codes are not grouped.
	function automatic logic match_word
	(
		input logic [INSTR_W-1:0] w,
		input logic [INSTR_W-1:0] opc
	);
		match_word = (w == opc);
	endfunction

	function automatic logic comparator_mode(input logic [NIB_W-1:0] ctl);
		comparator_mode = (ctl[MODE_SEL_BIT] == MODE_COMPARE);
	endfunction

	assign accepted        = instrValid && (state == ST_IDLE);
	assign isPageRead      = accepted && decode_page_read(instrWord);
	assign isIdxMove       = accepted && match_word(instrWord, OPC_IDX_MOVE);
	assign isCmpLoad       = accepted && match_word(instrWord, OPC_CMP_LOAD);
	assign isIntRead       = accepted && match_word(instrWord, OPC_INT_READ);
	assign compareMode     = comparator_mode(converterControl);
	assign next_stackLevel = SP_W'(stackLevel + 1'b1);

	// Three cycles: push and address, wait for memory, load and restore.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			state <= ST_IDLE;
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (isPageRead)
						state <= ST_FETCH;
				end
				ST_FETCH:
					state <= ST_LOAD;
				ST_LOAD:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Busy covers exactly the cycles in which the unit is not idle, so a core that waits
	// on busy alone never offers a word that would be dropped.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			busy <= 1'b0;
		else
			busy <= isPageRead || (state == ST_FETCH);
	end

	// Done marks the cycle in which results are written back, one pulse per finished word.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			done <= 1'b0;
		else
			done <= (state == ST_LOAD) || isIdxMove || isCmpLoad || isIntRead;
	end

	// The level is borrowed only for the length of the read; an overfull stack wraps
	// and overwrites the oldest entry, which is why software must leave a level free.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			stackLevel <= '0;
		else if (isPageRead)
			stackLevel <= next_stackLevel;
		else if (state == ST_LOAD)
			stackLevel <= SP_W'(stackLevel - 1'b1);
	end

	// Entries carry no reset: a level is always written before it is read back.
	always_ff @(posedge clk_sys)
	begin
		if (isPageRead)
			returnStack[next_stackLevel] <= pcIn;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			romRead <= 1'b0;
		else
			romRead <= isPageRead;
	end

	// The address holds after the read, so the memory output stays put until the load.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			romAddr <= '0;
		else if (isPageRead)
		begin
			romAddr.page <= instrWord[PAGE_W-1:0];
			romAddr.low  <= {indexBits, accIn};
		end
	end

	// The saved entry is read at the current level, before the decrement lands.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			pcWr <= '0;
		else
		begin
			pcWr.we <= (state == ST_LOAD);
			if (state == ST_LOAD)
				pcWr.pc <= returnStack[stackLevel];
		end
	end

	// At most one source is live in a cycle: the short operations need the idle state,
	// and the load never shares a cycle with a newly taken word.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			accWr <= '{we: 1'b0, data: NIB_RESET};
		else
		begin
			accWr.we <= (state == ST_LOAD) || isIdxMove || isIntRead;
			if (state == ST_LOAD)
				accWr.data <= romData[ROM_LO_NIB:0];
			else if (isIdxMove)
				accWr.data <= {1'b0, indexBits};
			else if (isIntRead)
				accWr.data <= interruptControlOne;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			regBWr <= '{we: 1'b0, data: NIB_RESET};
		else
		begin
			regBWr.we <= (state == ST_LOAD);
			if (state == ST_LOAD)
				regBWr.data <= romData[ROM_HI_NIB:ROM_LO_NIB+1];
		end
	end

	// In conversion mode the register is left untouched, so the load only pulses done.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			comparatorValue <= COMP_RESET;
		else if (isCmpLoad && compareMode)
			comparatorValue <= {regBIn, accIn};
	end

	// Both flags are tied low yet kept as flip-flops, so the core sees a registered
	// answer like every other output.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			carryWe <= 1'b0;
		else
			carryWe <= 1'b0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			skipNext <= 1'b0;
		else
			skipNext <= 1'b0;
	end

endmodule

// ===== verif/tarto_xfer_assertions.sv
// Concurrent checks on the transfer unit ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module tarto_xfer_assertions
	import tarto_pkg::*;
#(parameter int STACK_DEPTH = 8, parameter logic [9:0] OPC_IDX = 10'h051, OPC_CMP = 10'h239)
(
	input wire logic	clk_sys,
	input wire logic	rstn,
	input wire logic	instrValid,
	input wire logic [9:0]	instrWord,
	input wire logic [2:0]	indexBits,
	input wire logic [3:0]	accIn,
	input wire logic [3:0]	regBIn,
	input wire logic [3:0]	converterControl,
	input wire tarto_nib_wr_t	accWr,
	input wire tarto_pc_wr_t	pcWr,
	input wire logic [7:0]	comparatorValue,
	input wire logic [$clog2(STACK_DEPTH)-1:0]	stackLevel,
	input wire logic	busy,
	input wire logic	done,
	input wire logic	carryWe,
	input wire logic	skipNext
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_take(logic [9:0] w); instrValid && !busy && instrWord == w; endsequence
	sequence s_page; instrValid && !busy && instrWord[9:5] == PAGE_READ_OPC; endsequence
	property p_len; s_page |=> !done [*2] ##1 done; endproperty
	a_len: assert property (p_len) else $error("page length");
	property p_busy; s_page |=> busy [*2] ##1 !busy; endproperty
	a_busy: assert property (p_busy) else $error("busy span");
	property p_push; s_page |=> stackLevel == $past(stackLevel) + 1'b1; endproperty
	a_push: assert property (p_push) else $error("no push");
	property p_pop; s_page |-> ##3 (pcWr.we && stackLevel == $past(stackLevel, 3)); endproperty
	a_pop: assert property (p_pop) else $error("no pop");
	property p_idx; s_take(OPC_IDX) |=> accWr.we && accWr.data == {1'b0, $past(indexBits)};
	endproperty
	a_idx: assert property (p_idx) else $error("index move");
	property p_cmp; s_take(OPC_CMP) ##0 converterControl[MODE_SEL_BIT]
		|=> comparatorValue == {$past(regBIn), $past(accIn)}; endproperty
	a_cmp: assert property (p_cmp) else $error("compare load");
	property p_nop; s_take(OPC_CMP) ##0 !converterControl[MODE_SEL_BIT]
		|=> $stable(comparatorValue) && !accWr.we; endproperty
	a_nop: assert property (p_nop) else $error("load not idle");
	property p_flag; !carryWe && !skipNext; endproperty
	a_flag: assert property (p_flag) else $error("carry or skip");
endmodule
bind tarto_xfer tarto_xfer_assertions #(.STACK_DEPTH(STACK_DEPTH), .OPC_IDX(OPC_IDX_MOVE),
	.OPC_CMP(OPC_CMP_LOAD)) u_chk (.clk_sys(clk_sys), .rstn(rstn), .instrValid(instrValid),
	.instrWord(instrWord), .indexBits(indexBits), .accIn(accIn), .regBIn(regBIn),
	.converterControl(converterControl), .accWr(accWr), .pcWr(pcWr),
	.comparatorValue(comparatorValue), .stackLevel(stackLevel), .busy(busy), .done(done),
	.carryWe(carryWe), .skipNext(skipNext));

// ===== verif/test_tarto_xfer.sv
// Directed bench for the transfer unit, one task per instruction kind.
// Assumes the unit's fixed latencies; inputs change on rising edges.
`timescale 1ns/100ps
module test_tarto_xfer
	import tarto_pkg::*;
;
	logic	clk_sys = 1'b0, rstn = 1'b0, instrValid = 1'b0, romRead, busy, done, carryWe, skipNext;
	logic [9:0]	instrWord = 10'h000;
	tarto_pc_t	pcIn = 12'h5a3, romAddr;
	logic [2:0]	indexBits = 3'h6, stackLevel;
	logic [3:0]	accIn = 4'hf, regBIn = 4'hc, converterControl = 4'h0, interruptControlOne = 4'h9;
	logic [7:0]	romData = 8'h00, comparatorValue;
	tarto_nib_wr_t	accWr, regBWr;
	tarto_pc_wr_t	pcWr;
	int	n_errors = 0, check_count = 0;
	always #20 clk_sys = ~clk_sys;
	tarto_xfer uut (.clk_sys(clk_sys), .rstn(rstn), .instrValid(instrValid),
		.instrWord(instrWord), .pcIn(pcIn), .indexBits(indexBits), .accIn(accIn),
		.regBIn(regBIn), .converterControl(converterControl),
		.interruptControlOne(interruptControlOne), .romData(romData), .accWr(accWr),
		.regBWr(regBWr), .pcWr(pcWr), .romAddr(romAddr), .romRead(romRead),
		.comparatorValue(comparatorValue), .stackLevel(stackLevel), .busy(busy),
		.done(done), .carryWe(carryWe), .skipNext(skipNext));
	task automatic chk(input string what, input logic [15:0] seen, exp);
		check_count++;
		n_errors += int'(seen !== exp);
		if (seen !== exp)
			$display("ERROR %s expected %h seen %h", what, exp, seen);
	endtask
	task automatic issue(input logic [9:0] w);
		@(posedge clk_sys);
		instrValid <= 1'b1;
		instrWord <= w;
		// The word is taken at this edge; its one-cycle answers are read just after it.
		@(posedge clk_sys);
		instrValid <= 1'b0;
		#1;
	endtask
	task automatic t_page(input logic [4:0] p, input logic [7:0] rom);
		issue({PAGE_READ_OPC, p});
		chk("c1", {romRead, romAddr, stackLevel}, {1'b1, p, 7'h6f, 3'h1});
		@(posedge clk_sys);
		romData <= rom;
		@(posedge clk_sys);
		// Released data is inverted so a late sample cannot pass.
		romData <= ~rom;
		#1;
		chk("c3", {done, accWr, regBWr}, {2'h3, rom[3:0], 1'b1, rom[7:4]});
		chk("pc", {pcWr, stackLevel}, {1'b1, pcIn, 3'h0});
	endtask
	task automatic t_idx();
		issue(10'h051);
		chk("idx", {accWr, carryWe, skipNext}, {1'b1, 4'h6, 2'h0});
	endtask
	task automatic t_int();
		issue(10'h253);
		chk("int", accWr, {1'b1, 4'h9});
	endtask
	task automatic t_cmp(input logic mode, input logic [7:0] exp);
		@(posedge clk_sys);
		converterControl <= {mode, 3'h7};
		issue(10'h239);
		chk("cmp", {comparatorValue, accWr.we, done}, {exp, 2'h1});
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		t_page(5'h1f, 8'h3c);
		t_idx();
		t_int();
		t_cmp(1'b0, 8'h00);
		t_cmp(1'b1, 8'hcf);
		t_page(5'h0a, 8'hc5);
		complete_run();
	end
endmodule
